// ### common/bsrc_pkg.sv
// Constants and types shared by the boot strap and reset control block
package bsrc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NPROC = 4;
    localparam int CNT_W = 32;
    localparam int TAP_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TIMER_EN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IDS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_COUNT0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT3 = 8'h1c;

    // Control register fields
    localparam int CTL_MASTER_LSB = 0;
    localparam int CTL_FETCH_A = 2;
    localparam int CTL_FETCH_BCD = 3;
    localparam int CTL_TRI_A = 4;
    localparam int CTL_TRI_BCD = 5;
    localparam int CTL_FDRV_LSB = 8;
    localparam int CTL_FVAL_LSB = 12;
    localparam logic [DATA_W-1:0] CTL_RESET = 32'h0000_0000;

    // Status register fields
    localparam int ST_MODE_A_LSB = 0;
    localparam int ST_MODE_BCD_LSB = 3;
    localparam int ST_RSVD_A = 6;
    localparam int ST_RSVD_BCD = 7;
    localparam int ST_CAPTURED = 8;
    localparam int ST_FLAG_IN = 9;
    localparam int ST_EXP_LSB = 10;

    // Identity values wired per processor (A..D); id field stride
    localparam logic [2:0] PROC_ID [NPROC] = '{3'h1, 3'h2, 3'h3, 3'h4};
    localparam int ID_STRIDE = 4;

    // Processor index that stands for the first processor
    localparam logic [1:0] PROC_A = 2'h0;

    // Timer expired pulse length in module clock cycles
    localparam logic [2:0] TEXP_CYCLES = 3'h4;

    // Scan cell capture values
    localparam logic [NPROC-1:0] CAP_DR = 4'h0;
    localparam logic [NPROC-1:0] CAP_IR = 4'hf;

    typedef enum logic [2:0] {
        BSRC_EPROM, BSRC_HOST, BSRC_LINK, BSRC_NONE
    } bsrc_mode_t;

    typedef enum logic [TAP_W-1:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } bsrc_tap_t;

    function automatic bsrc_mode_t bsrc_decode(input logic e, input logic l,
                                                input logic b);
        if (e)
            return BSRC_EPROM;
        else if (!b)
            return BSRC_NONE;
        else if (l)
            return BSRC_LINK;
        else
            return BSRC_HOST;
    endfunction

    function automatic logic bsrc_reserved(input logic e, input logic l,
                                           input logic b);
        return (e & l) | (~e & l & ~b);
    endfunction
endpackage

// ### src/bsrc_top.sv
// Boot strap decode, boot select pins, timers and scan chain of the module
// What this block does
// - EPROM strap alone drives boot select as chip select
// - Select input high: host, or link with link strap
// - All straps low: no boot, run external memory
// - Low boot select input means no boot unless the EPROM strap is high
// - Only the bus master drives boot select
// - Boot select is driven only in EPROM mode
// - Processors B, C, D share one strap set
// - Timer expiry asserts output for four cycles
// - One common clock sets instruction rate
// - Module reset gives every processor known state
// - Test reset clears shared test state machine
// - Test clock asynchronous, common to all processors
// - Test data enters scan chain at processor A
// - Test data output comes from processor D
// - Fixed distinct identities, shared flag line common
// - Processor A has its own strap set
// - High EPROM strap selects 8-bit EPROM boot
module bsrc_top
    import bsrc_pkg::*;
(
    input wire logic pclk, // Module clock, also the instruction clock
    input wire logic presetn, // Module reset
    input wire logic clk_en, // Freezes all state while low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [bsrc_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [bsrc_pkg::DATA_W-1:0] pwdata, // APB write data
    output logic [bsrc_pkg::DATA_W-1:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic first_cpu_eprom_boot_strap, // Processor A EPROM strap
    input wire logic first_cpu_link_boot_strap, // Processor A link strap
    input wire logic first_cpu_boot_memory_select_i, // A select pin in
    output logic first_cpu_boot_memory_select_o, // A select pin out
    output logic first_cpu_boot_memory_select_oe, // A select drive
    input wire logic shared_eprom_boot_strap, // B, C, D EPROM strap
    input wire logic shared_link_boot_strap, // B, C, D link strap
    input wire logic shared_boot_memory_select_i, // B, C, D select pin in
    output logic shared_boot_memory_select_o, // B, C, D select pin out
    output logic shared_boot_memory_select_oe, // B, C, D select drive
    output bsrc_pkg::bsrc_mode_t boot_mode_a, // Decoded mode of A
    output bsrc_pkg::bsrc_mode_t boot_mode_bcd, // Decoded mode of B, C, D
    output logic [bsrc_pkg::NPROC-1:0] timer_expired_out, // Per processor
    input wire logic shared_flag_line_i, // Common flag line in
    output logic shared_flag_line_o, // Common flag line out
    output logic shared_flag_line_oe, // Common flag line drive
    input wire logic tck, // Test clock, asynchronous
    input wire logic tms, // Test mode select
    input wire logic tdi, // Test data in
    input wire logic trst_n, // Test reset
    output logic tdo // Test data out
);
    import bsrc_pkg::*;

    // Bus slave
    logic pready_r;
    logic pslverr_r;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] ctrl_r;
    logic [NPROC-1:0] timer_en_r;
    logic [CNT_W-1:0] count_r [NPROC];
    logic [CNT_W-1:0] count_nxt [NPROC];
    logic [2:0] pulse_r [NPROC];
    logic [2:0] pulse_nxt [NPROC];
    logic [NPROC-1:0] texp_r;

    wire acc = psel & penable;
    wire done = acc & pready_r;
    wire wr_done = done & pwrite;
    wire aligned = (paddr[1:0] == 2'h0);
    wire hit_ctrl = aligned & (paddr == OFS_CTRL);
    wire hit_ten = aligned & (paddr == OFS_TIMER_EN);
    wire hit_stat = aligned & (paddr == OFS_STATUS);
    wire hit_ids = aligned & (paddr == OFS_IDS);
    wire hit_cnt = aligned & (paddr >= OFS_COUNT0) & (paddr <= OFS_COUNT3);
    wire [1:0] cnt_idx = 2'((paddr - OFS_COUNT0) >> 2);
    wire mapped = hit_ctrl | hit_ten | hit_stat | hit_ids | hit_cnt;

    // Strap capture and decode
    logic captured_r;
    bsrc_mode_t mode_a_r;
    bsrc_mode_t mode_bcd_r;
    logic rsvd_a_r;
    logic rsvd_bcd_r;

    // A decodes its own straps; B, C, D share one set and one mode
    wire bsrc_mode_t mode_a_dec = bsrc_decode(first_cpu_eprom_boot_strap,
        first_cpu_link_boot_strap,
        first_cpu_boot_memory_select_i);
    wire bsrc_mode_t mode_bcd_dec = bsrc_decode(shared_eprom_boot_strap,
        shared_link_boot_strap,
        shared_boot_memory_select_i);
    // Reserved codes still fall into a defined mode, only flagged
    wire rsvd_a_dec = bsrc_reserved(first_cpu_eprom_boot_strap,
        first_cpu_link_boot_strap, first_cpu_boot_memory_select_i);
    wire rsvd_bcd_dec = bsrc_reserved(shared_eprom_boot_strap,
        shared_link_boot_strap, shared_boot_memory_select_i);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_r <= 1'b0;
            mode_a_r <= BSRC_NONE;
            mode_bcd_r <= BSRC_NONE;
            rsvd_a_r <= 1'b0;
            rsvd_bcd_r <= 1'b0;
        end else if (clk_en && !captured_r) begin
            // Caught once at release; the pin later turns output
            captured_r <= 1'b1;
            mode_a_r <= mode_a_dec;
            mode_bcd_r <= mode_bcd_dec;
            rsvd_a_r <= rsvd_a_dec;
            rsvd_bcd_r <= rsvd_bcd_dec;
        end
    end

    // Boot select pins
    wire [1:0] master = ctrl_r[CTL_MASTER_LSB +: 2];
    wire a_is_master = (master == PROC_A);
    wire a_eprom = captured_r & (mode_a_r == BSRC_EPROM);
    wire bcd_eprom = captured_r & (mode_bcd_r == BSRC_EPROM);
    // Outside EPROM mode the pin is an input, so never driven by us
    wire a_oe_nxt = a_eprom & a_is_master & ~ctrl_r[CTL_TRI_A];
    wire bcd_oe_nxt = bcd_eprom & ~a_is_master
                      & ~ctrl_r[CTL_TRI_BCD];
    wire a_cs_nxt = ~ctrl_r[CTL_FETCH_A];
    wire bcd_cs_nxt = ~ctrl_r[CTL_FETCH_BCD];

    logic a_oe_r;
    logic bcd_oe_r;
    logic a_cs_r;
    logic bcd_cs_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_oe_r <= 1'b0;
            bcd_oe_r <= 1'b0;
            a_cs_r <= 1'b1;
            bcd_cs_r <= 1'b1;
        end else if (clk_en) begin
            a_oe_r <= a_oe_nxt;
            bcd_oe_r <= bcd_oe_nxt;
            a_cs_r <= a_cs_nxt;
            bcd_cs_r <= bcd_cs_nxt;
        end
    end

    // Shared flag line: lowest driving processor wins
    wire [NPROC-1:0] fdrv = ctrl_r[CTL_FDRV_LSB +: NPROC];
    wire [NPROC-1:0] fval = ctrl_r[CTL_FVAL_LSB +: NPROC];
    wire [NPROC-1:0] fsel = fdrv & (~fdrv + 4'h1);
    wire flag_oe_nxt = |fdrv;
    wire flag_o_nxt = |(fsel & fval);
    logic flag_oe_r;
    logic flag_o_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_oe_r <= 1'b0;
            flag_o_r <= 1'b0;
        end else if (clk_en) begin
            flag_oe_r <= flag_oe_nxt;
            flag_o_r <= flag_o_nxt;
        end
    end

    // Timers, one per processor, all on the common clock
    for (genvar i = 0; i < NPROC; i++) begin : g_tmr
        wire wr_cnt = wr_done & hit_cnt & (cnt_idx == 2'(i));
        wire expire = timer_en_r[i] & (count_r[i] == 32'h1) & ~wr_cnt;
        assign count_nxt[i] = wr_cnt ? pwdata
                            : (timer_en_r[i] && count_r[i] != 32'h0)
                            ? count_r[i] - 32'h1 : count_r[i];
        assign pulse_nxt[i] = expire ? TEXP_CYCLES
                            : (pulse_r[i] != 3'h0) ? pulse_r[i] - 3'h1
                            : pulse_r[i];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                count_r[i] <= 32'h0;
                pulse_r[i] <= 3'h0;
                texp_r[i] <= 1'b0;
            end else if (clk_en) begin
                count_r[i] <= count_nxt[i];
                pulse_r[i] <= pulse_nxt[i];
                texp_r[i] <= (pulse_nxt[i] != 3'h0);
            end
        end
    end

    // Register read mux
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] ids;
    always_comb begin
        status = '0;
        status[ST_MODE_A_LSB +: 3] = mode_a_r;
        status[ST_MODE_BCD_LSB +: 3] = mode_bcd_r;
        status[ST_RSVD_A] = rsvd_a_r;
        status[ST_RSVD_BCD] = rsvd_bcd_r;
        status[ST_CAPTURED] = captured_r;
        status[ST_FLAG_IN] = shared_flag_line_i;
        status[ST_EXP_LSB +: NPROC] = texp_r;
        ids = '0;
        for (int k = 0; k < NPROC; k++) begin
            ids[k*ID_STRIDE +: 3] = PROC_ID[k];
        end
    end

    wire [DATA_W-1:0] rd_mux = hit_ctrl ? ctrl_r
                             : hit_ten ? {28'h0, timer_en_r}
                             : hit_stat ? status
                             : hit_ids ? ids
                             : hit_cnt ? count_r[cnt_idx]
                             : 32'h0;

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else if (clk_en) begin
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~mapped;
            prdata_r <= (acc & ~pready_r & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTL_RESET;
            timer_en_r <= 4'h0;
        end else if (clk_en) begin
            if (wr_done && hit_ctrl)
                ctrl_r <= pwdata;
            if (wr_done && hit_ten)
                timer_en_r <= pwdata[NPROC-1:0];
        end
    end

    // Test access: tck only sampled, never used as a clock
    logic tck_s1;
    logic tck_s2;
    logic tck_s3;
    logic tms_s1;
    logic tms_s2;
    logic tdi_s1;
    logic tdi_s2;
    logic trst_s1;
    logic trst_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
            trst_s1 <= 1'b0;
            trst_s2 <= 1'b0;
        end else if (clk_en) begin
            tck_s1 <= tck;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi;
            tdi_s2 <= tdi_s1;
            trst_s1 <= trst_n;
            trst_s2 <= trst_s1;
        end
    end

    wire tck_rise = tck_s2 & ~tck_s3;
    wire tck_fall = ~tck_s2 & tck_s3;

    bsrc_tap_t tap_r;
    bsrc_tap_t tap_nxt;
    always_comb begin
        unique case (tap_r)
            TAP_RESET: tap_nxt = tms_s2 ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_nxt = tms_s2 ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_nxt = tms_s2 ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_nxt = tms_s2 ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_nxt = tms_s2 ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_nxt = tms_s2 ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_nxt = tms_s2 ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_nxt = tms_s2 ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_nxt = tms_s2 ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_nxt = tms_s2 ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_nxt = tms_s2 ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_nxt = tms_s2 ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_nxt = tms_s2 ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_nxt = tms_s2 ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_nxt = tms_s2 ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_nxt = tms_s2 ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // One cell per processor, A first and D last
    logic [NPROC-1:0] chain_r;
    logic tdo_r;
    wire shifting = (tap_r == TAP_SH_DR) | (tap_r == TAP_SH_IR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_r <= TAP_RESET;
            chain_r <= CAP_DR;
            tdo_r <= 1'b0;
        end else if (clk_en) begin
            if (!trst_s2) begin
                tap_r <= TAP_RESET;
            end else if (tck_rise) begin
                tap_r <= tap_nxt;
                if (shifting)
                    chain_r <= {chain_r[NPROC-2:0], tdi_s2};
                else if (tap_r == TAP_CAP_DR)
                    chain_r <= CAP_DR;
                else if (tap_r == TAP_CAP_IR)
                    chain_r <= CAP_IR;
            end
            if (tck_fall && shifting)
                tdo_r <= chain_r[NPROC-1];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign first_cpu_boot_memory_select_o = a_cs_r;
    assign first_cpu_boot_memory_select_oe = a_oe_r;
    assign shared_boot_memory_select_o = bcd_cs_r;
    assign shared_boot_memory_select_oe = bcd_oe_r;
    assign boot_mode_a = mode_a_r;
    assign boot_mode_bcd = mode_bcd_r;
    assign timer_expired_out = texp_r;
    assign shared_flag_line_o = flag_o_r;
    assign shared_flag_line_oe = flag_oe_r;
    assign tdo = tdo_r;
endmodule

// ### test/bsrc_board_model.sv
// Board wiring model: boot select straps and the common flag line
module bsrc_board_model (
    input wire logic pclk, // Module clock
    input wire logic strap_a, // Hardwired select level, A
    input wire logic strap_bcd, // Hardwired select level, B/C/D
    input wire logic sel_o_a, // A pin value
    input wire logic sel_oe_a, // A pin drive
    input wire logic sel_o_bcd, // B/C/D pin value
    input wire logic sel_oe_bcd, // B/C/D pin drive
    input wire logic flag_o, // Flag value
    input wire logic flag_oe, // Flag drive
    output logic sel_a, // A pin level
    output logic sel_bcd, // B/C/D pin level
    output logic flag // Flag line level
);
    logic flag_last_r = 1'b0;

    // Fixed wiring; the device overrides it only while driving
    assign sel_a = sel_oe_a ? sel_o_a : strap_a;
    assign sel_bcd = sel_oe_bcd ? sel_o_bcd : strap_bcd;
    // No pull on the flag line, so an idle line must not look stable
    assign flag = flag_oe ? flag_o : ~flag_last_r;

    always_ff @(posedge pclk) begin
        flag_last_r <= flag;
    end
endmodule

// ### test/bsrc_monitor.sv
// Checker for boot select drive, boot modes and timer expiry outputs
module bsrc_monitor
    import bsrc_pkg::*;
(
    input wire logic pclk, // Module clock
    input wire logic presetn, // Module reset
    input wire logic first_cpu_boot_memory_select_oe, // A select drive
    input wire logic shared_boot_memory_select_oe, // B/C/D select drive
    input bsrc_pkg::bsrc_mode_t boot_mode_a, // A mode
    input bsrc_pkg::bsrc_mode_t boot_mode_bcd, // B/C/D mode
    input wire logic [bsrc_pkg::NPROC-1:0] timer_expired_out // Expiry
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    oe_a_eprom_a: assert property (
        first_cpu_boot_memory_select_oe |-> boot_mode_a == BSRC_EPROM)
        else $error("A select driven off EPROM");
    oe_bcd_eprom_a: assert property (
        shared_boot_memory_select_oe |-> boot_mode_bcd == BSRC_EPROM)
        else $error("BCD select off EPROM");
    one_master_a: assert property (
        !(first_cpu_boot_memory_select_oe && shared_boot_memory_select_oe))
        else $error("both groups drive boot select");
    expiry_a_len_a: assert property ($rose(timer_expired_out[0]) |->
        timer_expired_out[0] [*4] ##1 !timer_expired_out[0])
        else $error("A expiry pulse not four cycles");
    expiry_d_len_a: assert property ($rose(timer_expired_out[3]) |->
        timer_expired_out[3] [*4] ##1 !timer_expired_out[3])
        else $error("D expiry pulse not four cycles");
    mode_a_hold_a: assert property ($past(presetn, 2) |->
        $stable(boot_mode_a)) else $error("A mode changed in run");
    mode_bcd_hold_a: assert property ($past(presetn, 2) |->
        $stable(boot_mode_bcd)) else $error("BCD mode changed in run");
    reset_state_a: assert property ($rose(presetn) |->
        boot_mode_a == BSRC_NONE && boot_mode_bcd == BSRC_NONE &&
        timer_expired_out == 4'h0 && !first_cpu_boot_memory_select_oe &&
        !shared_boot_memory_select_oe)
        else $error("outputs not in reset state");
endmodule

bind bsrc_top bsrc_monitor u_mon (
    .pclk(pclk), .presetn(presetn),
    .first_cpu_boot_memory_select_oe(first_cpu_boot_memory_select_oe),
    .shared_boot_memory_select_oe(shared_boot_memory_select_oe),
    .boot_mode_a(boot_mode_a),
    .boot_mode_bcd(boot_mode_bcd), .timer_expired_out(timer_expired_out)
);

// ### test/test_bsrc_top.sv
// Self-checking bench for strap decode, boot select, timers and scan
module test_bsrc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bsrc_pkg::*;

    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, er;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
    logic ea = 1'b0, la = 1'b0, sa = 1'b0, eb = 1'b0, lb = 1'b0, sb = 1'b0;
    logic sel_a, sel_b, bo_a, boe_a, bo_b, boe_b, fo, foe, fl;
    bsrc_mode_t mode_a, mode_b;
    logic [NPROC-1:0] texp;
    logic tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b0, tdo;
    int err_count = 0;
    int n_compared = 0;

    bsrc_top u_dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .first_cpu_eprom_boot_strap(ea), .first_cpu_link_boot_strap(la),
        .first_cpu_boot_memory_select_i(sel_a),
        .first_cpu_boot_memory_select_o(bo_a),
        .first_cpu_boot_memory_select_oe(boe_a),
        .shared_eprom_boot_strap(eb), .shared_link_boot_strap(lb),
        .shared_boot_memory_select_i(sel_b),
        .shared_boot_memory_select_o(bo_b),
        .shared_boot_memory_select_oe(boe_b), .boot_mode_a(mode_a),
        .boot_mode_bcd(mode_b), .timer_expired_out(texp),
        .shared_flag_line_i(fl), .shared_flag_line_o(fo),
        .shared_flag_line_oe(foe), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo)
    );

    bsrc_board_model u_board (
        .pclk(pclk), .strap_a(sa), .strap_bcd(sb), .sel_o_a(bo_a),
        .sel_oe_a(boe_a), .sel_o_bcd(bo_b), .sel_oe_bcd(boe_b),
        .flag_o(fo), .flag_oe(foe), .sel_a(sel_a), .sel_bcd(sel_b),
        .flag(fl)
    );

    initial begin
        forever #20 pclk = ~pclk;
    end

    task end_of_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp,
             input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic bsrc_mode_t emode(input logic [2:0] s);
        return s[2] ? BSRC_EPROM : !s[0] ? BSRC_NONE :
            s[1] ? BSRC_LINK : BSRC_HOST;
    endfunction

    function automatic logic resv(input logic [2:0] s);
        return (s[2] & s[1]) | (~s[2] & s[1] & ~s[0]);
    endfunction

    // This task moves straps only while reset is held, as wiring would
    task boot(input logic [2:0] a, input logic [2:0] b);
        @(posedge pclk);
        presetn <= 1'b0;
        {ea, la, sa} <= a;
        {eb, lb, sb} <= b;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task sel_case(input logic [31:0] c, input logic [3:0] e);
        apb(1'b1, OFS_CTRL, c);
        @(posedge pclk);
        #1;
        chk("boot_sel", e, {bo_a, boe_a, bo_b, boe_b});
    endtask

    task tck_bit(input logic m, input logic d);
        @(posedge pclk);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge pclk);
        tck <= 1'b1;
        repeat (4) @(posedge pclk);
        tck <= 1'b0;
        repeat (6) @(posedge pclk);
        #1;
    endtask

    task t_decode();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(7 - i);
            boot(3'(i), c);
            #1;
            chk("mode_a", emode(3'(i)), mode_a);
            chk("mode_bcd", emode(c), mode_b);
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("status", {23'h0, 1'b1, resv(c), resv(3'(i)), emode(c),
                emode(3'(i))}, rd & 32'h1ff);
            @(posedge pclk);
            ea <= ~ea;
            sa <= ~sa;
            repeat (3) @(posedge pclk);
            #1;
            chk("mode_held", emode(3'(i)), mode_a);
        end
    endtask

    task t_bms();
        boot(3'h5, 3'h5);
        sel_case(32'h04, 4'b0110);
        sel_case(32'h09, 4'b1001);
        sel_case(32'h29, 4'b1000);
        boot(3'h1, 3'h3);
        sel_case(32'h0c, 4'b0000);
    endtask

    task t_regs();
        boot(3'h0, 3'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_reset", CTL_RESET, rd);
        apb(1'b0, OFS_IDS, 32'h0);
        chk("ids", 32'h4321, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, OFS_CTRL, 32'h4400);
        @(posedge pclk);
        #1;
        chk("flag_drive", 32'h3, {fo, foe});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("flag_in", 32'h1, rd[ST_FLAG_IN]);
    endtask

    task t_timer();
        int n;
        for (int k = 0; k < NPROC; k++) begin
            apb(1'b1, OFS_COUNT0 + 8'(4 * k), 32'h3);
            apb(1'b1, OFS_TIMER_EN, 32'(1 << k));
            n = 0;
            repeat (30) begin
                @(posedge pclk);
                #1;
                n += int'(texp[k]);
            end
            chk("expiry_len", 32'h4, n);
            apb(1'b1, OFS_TIMER_EN, 32'h0);
        end
    endtask

    // Capture loads zeros, so the pattern shows up after three shifts
    task t_scan();
        logic [7:0] pat;
        pat = 8'h2d;
        @(posedge pclk);
        trst_n <= 1'b0;
        repeat (5) @(posedge pclk);
        trst_n <= 1'b1;
        tck_bit(1'b0, 1'b0);
        tck_bit(1'b1, 1'b0);
        tck_bit(1'b0, 1'b0);
        tck_bit(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            tck_bit(1'b0, pat[i]);
            chk("tdo", (i < 3) ? 1'b0 : pat[i-3], tdo);
        end
    endtask

    initial begin
        t_decode();
        t_bms();
        t_regs();
        t_timer();
        t_scan();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        end_of_test();
    end
endmodule
